// ==== design/aux_timer_cfg.svh ====
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by bare name from the timer module, the checker and the bench
`ifndef AUX_TIMER_CFG_SVH
`define AUX_TIMER_CFG_SVH

// ==========================================================
// Register offsets (byte index on the plain register port)
`define ADDR_CONTROL 4'h0
`define ADDR_MODE 4'h1
`define ADDR_RELOAD_LOW 4'h2
`define ADDR_RELOAD_HIGH 4'h3
`define ADDR_COUNT_LOW 4'h4
`define ADDR_COUNT_HIGH 4'h5
`define ADDR_IRQ_ENABLE 4'h6

// ==========================================================
// Control register fields
`define CTL_OVERFLOW 7
`define CTL_EXT_FLAG 6
`define CTL_RX_CLK 5
`define CTL_TX_CLK 4
`define CTL_EXT_EN 3
`define CTL_RUN 2
`define CTL_CT_SEL 1
`define CTL_CAPTURE 0

// Mode register and interrupt enable fields
`define MODE_CLK_OUT_EN 1
`define MODE_DOWN_EN 0
`define IE_GLOBAL 7
`define IE_AUX_TIMER 5

// ==========================================================
// Reset values
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
`define ALL_ONES_WORD 16'hFFFF

// ==========================================================
// Prescale: state time is 2 oscillator clocks, machine cycle 12
`define STATE_DIV 4'h2
`define MACHINE_DIV 4'hC

`endif

// ==== design/aux_timer_pkg.sv ====
// Types shared by the auxiliary timer design
// Assumes the constants header sits beside it in design/
package aux_timer_pkg;

   // ==========================================================
   // Register port request
   typedef struct packed
   {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } reg_req_type;

   // ==========================================================
   // Counting mode of the timer
   typedef enum logic [1:0]
   {
      MODE_IDLE,
      MODE_TIMER,
      MODE_BAUD,
      MODE_CLKOUT
   } count_mode_type;

endpackage : aux_timer_pkg

// ==== design/edge_sync.sv ====
// Two-stage synchroniser with falling-edge detect for a pin input
// Assumes the pin is asynchronous to clock_i
`timescale 1ns/1ns
module edge_sync
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic enable_i,
   // Pin and results
   input wire logic pin_i,
   output logic level_o,
   output logic fall_o
);

   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // ==========================================================
   // Sync chain; first stage feeds only the second
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         meta_reg <= 1'b1;
         sync_reg <= 1'b1;
         last_reg <= 1'b1;
      end
      else if (enable_i)
      begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   // Edge is one cycle wide after the second stage
   assign level_o = sync_reg;
   assign fall_o = last_reg & ~sync_reg;

endmodule : edge_sync

// ==== design/aux_timer.sv ====
// Auxiliary 16-bit timer: baud generator, clock-out and interrupt request
// Assumes a byte register port and an oscillator-rate clock_i
//
// The strobed register port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`include "aux_timer_cfg.svh"
module aux_timer
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic enable_i,
   // Register port
   input wire aux_timer_pkg::reg_req_type req_i,
   output logic [7:0] rdata_o,
   // Pins
   input wire logic count_pin_i,
   input wire logic external_trigger_pin_i,
   output logic clock_out_pin_o,
   output logic clock_out_pin_oe_n_o,
   // Serial port baud ticks and timer 1 overflow
   input wire logic timer1_tick_i,
   output logic tx_baud_tick_o,
   output logic rx_baud_tick_o,
   // Interrupt request
   output logic irq_o
);
   import aux_timer_pkg::*;

   logic [7:0] aux_timer_control_reg;
   logic [7:0] aux_timer_mode_reg;
   logic [7:0] interrupt_enable_reg;
   logic [15:0] reload_reg;
   logic [15:0] count_reg;
   logic [3:0] prescale_reg;
   logic clock_out_pin_reg;
   logic [7:0] rdata_reg;
   logic tx_tick_reg;
   logic rx_tick_reg;
   logic irq_reg;
   logic count_fall;
   logic trigger_fall;
   logic tx_clock_select;
   logic rx_clock_select;
   logic counter_timer_select;
   logic run_control_bit;
   logic external_edge_enable;
   logic clock_out_enable;
   logic baud_mode;
   logic clkout_mode;
   logic [3:0] div_sel;
   logic prescale_tick;
   logic count_step;
   logic overflow;
   logic set_overflow;
   logic set_edge;
   logic wr_ctl;
   logic [15:0] count_next;
   count_mode_type mode_now;

   // ==========================================================
   // Pin synchronisers
   edge_sync count_sync
   (
      .clock_i (clock_i),
      .rst_i (rst_i),
      .enable_i (enable_i),
      .pin_i (count_pin_i),
      .level_o (),
      .fall_o (count_fall)
   );

   edge_sync trigger_sync
   (
      .clock_i (clock_i),
      .rst_i (rst_i),
      .enable_i (enable_i),
      .pin_i (external_trigger_pin_i),
      .level_o (),
      .fall_o (trigger_fall)
   );

   // ==========================================================
   // Control field decode
   assign tx_clock_select = aux_timer_control_reg[`CTL_TX_CLK];
   assign rx_clock_select = aux_timer_control_reg[`CTL_RX_CLK];
   assign counter_timer_select = aux_timer_control_reg[`CTL_CT_SEL];
   assign run_control_bit = aux_timer_control_reg[`CTL_RUN];
   assign external_edge_enable = aux_timer_control_reg[`CTL_EXT_EN];
   assign clock_out_enable = aux_timer_mode_reg[`MODE_CLK_OUT_EN];
   assign baud_mode = tx_clock_select | rx_clock_select;
   assign clkout_mode = ~counter_timer_select & clock_out_enable;

   // Mode summary; both special modes share the fast count rate
   always_comb
   begin
      if (baud_mode)
         mode_now = MODE_BAUD;
      else if (clkout_mode)
         mode_now = MODE_CLKOUT;
      else if (run_control_bit)
         mode_now = MODE_TIMER;
      else
         mode_now = MODE_IDLE;
   end

   // Rate select: state time for baud or clock-out, else machine cycle
   assign div_sel = (mode_now == MODE_BAUD || mode_now == MODE_CLKOUT)
      ? `STATE_DIV : `MACHINE_DIV;
   assign prescale_tick = (prescale_reg == div_sel - 4'h1);

   // External count clocks ignore the prescaler
   always_comb
   begin
      if (counter_timer_select)
         count_step = run_control_bit & count_fall;
      else
         count_step = run_control_bit & prescale_tick;
   end

   assign overflow = count_step && (count_reg == `ALL_ONES_WORD);
   assign wr_ctl = req_i.write && req_i.addr == `ADDR_CONTROL;
   // Overflow flags only outside baud and clock-out modes
   assign set_overflow = overflow && !baud_mode && !clkout_mode;
   assign set_edge = external_edge_enable && trigger_fall;

   // ==========================================================
   // Prescaler; clears when stopped, on its tick, or when past a new smaller divide
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         prescale_reg <= 4'h0;
      else if (enable_i)
      begin
         if (!run_control_bit || prescale_tick || prescale_reg >= div_sel)
            prescale_reg <= 4'h0;
         else
            prescale_reg <= prescale_reg + 4'h1;
      end
   end

   // Next count: reload on overflow in every mode, else step by one
   always_comb
   begin
      count_next = count_reg;
      if (overflow)
         count_next = reload_reg;
      else if (count_step)
         count_next = count_reg + 16'h0001;
   end

   // ==========================================================
   // Counter and software writes; a written byte wins over a hardware step
   // and the other byte takes the stepped value
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         count_reg <= `RESET_WORD;
      else if (enable_i)
      begin
         if (req_i.write && req_i.addr == `ADDR_COUNT_LOW)
            count_reg <= {count_next[15:8], req_i.wdata};
         else if (req_i.write && req_i.addr == `ADDR_COUNT_HIGH)
            count_reg <= {req_i.wdata, count_next[7:0]};
         else
            count_reg <= count_next;
      end
   end

   // Reload pair, written by software only
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         reload_reg <= `RESET_WORD;
      else if (enable_i && req_i.write)
      begin
         if (req_i.addr == `ADDR_RELOAD_LOW)
            reload_reg[7:0] <= req_i.wdata;
         else if (req_i.addr == `ADDR_RELOAD_HIGH)
            reload_reg[15:8] <= req_i.wdata;
      end
   end

   // ==========================================================
   // Control register; hardware set wins over a software clear
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         aux_timer_control_reg <= `RESET_BYTE;
      else if (enable_i)
      begin
         if (wr_ctl)
            aux_timer_control_reg <= req_i.wdata;
         if (set_overflow)
            aux_timer_control_reg[`CTL_OVERFLOW] <= 1'b1;
         if (set_edge)
            aux_timer_control_reg[`CTL_EXT_FLAG] <= 1'b1;
      end
   end

   // Mode and interrupt enable registers
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         aux_timer_mode_reg <= `RESET_BYTE;
         interrupt_enable_reg <= `RESET_BYTE;
      end
      else if (enable_i && req_i.write)
      begin
         if (req_i.addr == `ADDR_MODE)
            aux_timer_mode_reg <= req_i.wdata & 8'h03;
         if (req_i.addr == `ADDR_IRQ_ENABLE)
            interrupt_enable_reg <= req_i.wdata & 8'hBF; // Bit 6 reserved
      end
   end

   // ==========================================================
   // Clock-out pin: toggles per overflow, so period is 2 overflows
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         clock_out_pin_reg <= 1'b1;
         clock_out_pin_oe_n_o <= 1'b1;
      end
      else if (enable_i)
      begin
         clock_out_pin_oe_n_o <= ~clkout_mode;
         if (clkout_mode && overflow)
            clock_out_pin_reg <= ~clock_out_pin_reg;
      end
   end
   assign clock_out_pin_o = clock_out_pin_reg;

   // Baud ticks: serial port divides by 16 more for modes 1 and 3
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         tx_tick_reg <= 1'b0;
         rx_tick_reg <= 1'b0;
      end
      else if (enable_i)
      begin
         tx_tick_reg <= tx_clock_select ? overflow : timer1_tick_i;
         rx_tick_reg <= rx_clock_select ? overflow : timer1_tick_i;
      end
   end
   assign tx_baud_tick_o = tx_tick_reg;
   assign rx_baud_tick_o = rx_tick_reg;

   // ==========================================================
   // Interrupt request from the flag state, gated by both enables
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         irq_reg <= 1'b0;
      else if (enable_i)
         irq_reg <= (aux_timer_control_reg[`CTL_OVERFLOW]
            | aux_timer_control_reg[`CTL_EXT_FLAG])
            & interrupt_enable_reg[`IE_AUX_TIMER]
            & interrupt_enable_reg[`IE_GLOBAL];
   end
   assign irq_o = irq_reg;

   // ==========================================================
   // Read data, one cycle after the read strobe, zero otherwise
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
         rdata_reg <= `RESET_BYTE;
      else if (enable_i)
      begin
         rdata_reg <= `RESET_BYTE;
         if (req_i.read)
         begin
            unique case (req_i.addr)
               `ADDR_CONTROL: rdata_reg <= aux_timer_control_reg;
               `ADDR_MODE: rdata_reg <= aux_timer_mode_reg;
               `ADDR_RELOAD_LOW: rdata_reg <= reload_reg[7:0];
               `ADDR_RELOAD_HIGH: rdata_reg <= reload_reg[15:8];
               `ADDR_COUNT_LOW: rdata_reg <= count_reg[7:0];
               `ADDR_COUNT_HIGH: rdata_reg <= count_reg[15:8];
               `ADDR_IRQ_ENABLE: rdata_reg <= interrupt_enable_reg;
               default: rdata_reg <= `RESET_BYTE;
            endcase
         end
      end
   end
   assign rdata_o = rdata_reg;

endmodule : aux_timer

// ==== tb/aux_timer_sva.sv ====
// Port checker for the auxiliary timer
// Assumes one clock domain and software-only control bits shadowed here
`timescale 1ns/1ns
`include "aux_timer_cfg.svh"
module aux_timer_sva
(
   // Clock, reset, enable
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic enable_i,
   // Observed ports
   input wire aux_timer_pkg::reg_req_type req_i,
   input wire logic [7:0] rdata_o,
   input wire logic clock_out_pin_o,
   input wire logic clock_out_pin_oe_n_o,
   input wire logic timer1_tick_i,
   input wire logic tx_baud_tick_o,
   input wire logic rx_baud_tick_o,
   input wire logic irq_o
);
   import aux_timer_pkg::*;
   logic [7:0] ctl_reg;
   logic [7:0] mode_reg;
   logic [7:0] ie_reg;
   logic clk_mode;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Shadow of written bits; hardware flags are not tracked
   always_ff @(posedge clock_i)
   begin
      if (rst_i)
      begin
         ctl_reg <= 8'h00;
         mode_reg <= 8'h00;
         ie_reg <= 8'h00;
      end
      else if (req_i.write && enable_i)
      begin
         if (req_i.addr == `ADDR_CONTROL) ctl_reg <= req_i.wdata;
         if (req_i.addr == `ADDR_MODE) mode_reg <= req_i.wdata;
         if (req_i.addr == `ADDR_IRQ_ENABLE) ie_reg <= req_i.wdata;
      end
   end
   // Clock-out wanted: select clear and enable set
   assign clk_mode = mode_reg[`MODE_CLK_OUT_EN] && !ctl_reg[`CTL_CT_SEL];
   // ==========================================================
   // Assertions
   rdata_idle_a: assert property (!$past(req_i.read && enable_i) |-> rdata_o == 8'h00)
      else $error("read data not zero outside answer");
   ie_read_a: assert property ($past(req_i.read && req_i.addr == `ADDR_IRQ_ENABLE)
      |-> rdata_o == ($past(ie_reg) & 8'hBF)) else $error("enable register read wrong");
   irq_gate_a: assert property (irq_o |-> $past(ie_reg[7] && ie_reg[5]))
      else $error("interrupt raised while disabled");
   tx_source_a: assert property ($past(enable_i) && !$past(ctl_reg[4])
      && !$past(ctl_reg[4], 2) |-> tx_baud_tick_o == $past(timer1_tick_i))
      else $error("tx tick not from timer 1");
   rx_source_a: assert property ($past(enable_i) && !$past(ctl_reg[5])
      && !$past(ctl_reg[5], 2) |-> rx_baud_tick_o == $past(timer1_tick_i))
      else $error("rx tick not from timer 1");
   tx_spacing_a: assert property (ctl_reg[4] && $past(ctl_reg[4]) && tx_baud_tick_o
      |=> !tx_baud_tick_o) else $error("baud ticks closer than a state time");
   pin_spacing_a: assert property (!clock_out_pin_oe_n_o && $changed(clock_out_pin_o)
      |=> $stable(clock_out_pin_o)) else $error("clock-out toggled too fast");
   oe_mode_a: assert property ($past(clk_mode) == clk_mode && $past(clk_mode, 2) == clk_mode
      |-> clock_out_pin_oe_n_o == !clk_mode) else $error("pin enable disagrees with mode");
endmodule : aux_timer_sva

bind aux_timer aux_timer_sva sva_inst
(
   .clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i), .req_i(req_i), .rdata_o(rdata_o),
   .clock_out_pin_o(clock_out_pin_o), .clock_out_pin_oe_n_o(clock_out_pin_oe_n_o),
   .timer1_tick_i(timer1_tick_i), .tx_baud_tick_o(tx_baud_tick_o),
   .rx_baud_tick_o(rx_baud_tick_o), .irq_o(irq_o)
);

// ==== tb/serial_load_model.sv ====
// Far side: serial port baud inputs and the load on the clock-out pin
// Assumes the bench clears the counts before each measuring window
`timescale 1ns/1ns
module serial_load_model
(
   // Clock and count clear
   input wire logic clock_i,
   input wire logic clear_i,
   // Baud ticks and pin wire level
   input wire logic tx_tick_i,
   input wire logic rx_tick_i,
   input wire logic pin_i,
   // Counts seen
   output int tx_count_o,
   output int rx_count_o,
   output int rise_count_o
);
   logic pin_last = 1'b1;
   // ==========================================================
   // Each tick is one event; a stuck-high tick counts every cycle
   always @(posedge clock_i)
   begin
      pin_last <= pin_i;
      if (clear_i)
      begin
         tx_count_o <= 0;
         rx_count_o <= 0;
         rise_count_o <= 0;
      end
      else
      begin
         tx_count_o <= tx_count_o + int'(tx_tick_i);
         rx_count_o <= rx_count_o + int'(rx_tick_i);
         rise_count_o <= rise_count_o + int'(pin_i && !pin_last);
      end
   end
endmodule : serial_load_model

// ==== tb/tb_top.sv ====
// Self-checking bench for the auxiliary timer
// Assumes design package, header, checker and far-side model compile first
`timescale 1ns/1ns
`include "aux_timer_cfg.svh"
module tb_top;
   import aux_timer_pkg::*;
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic enable_i = 1'b1;
   reg_req_type req = '0;
   logic pin_drv = 1'b1;
   logic trig = 1'b1;
   logic t1_tick = 1'b0;
   logic clear = 1'b1;
   logic [7:0] rdata;
   logic pin_out, oe_n, tx_tick, rx_tick, irq;
   int tx_n, rx_n, rise_n, irq_n;
   int n_fail = 0;
   int check_count = 0;
   int cycles = 0;
   // Pin has a pull-up; either side may pull it low
   wire logic pin_wire = (oe_n ? 1'b1 : pin_out) & pin_drv;
   // ==========================================================
   // Clock, timer 1 stand-in and hang guard
   always #2 clock_i = ~clock_i;
   always @(posedge clock_i)
   begin
      cycles <= cycles + 1;
      t1_tick <= (cycles % 10 == 9);
      if (cycles == 4000)
      begin
         n_fail++;
         complete_run;
      end
   end
   aux_timer uut
   (
      .clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i), .req_i(req), .rdata_o(rdata),
      .count_pin_i(pin_wire), .external_trigger_pin_i(trig), .clock_out_pin_o(pin_out),
      .clock_out_pin_oe_n_o(oe_n), .timer1_tick_i(t1_tick), .tx_baud_tick_o(tx_tick),
      .rx_baud_tick_o(rx_tick), .irq_o(irq)
   );
   serial_load_model load
   (
      .clock_i(clock_i), .clear_i(clear), .tx_tick_i(tx_tick), .rx_tick_i(rx_tick),
      .pin_i(pin_wire), .tx_count_o(tx_n), .rx_count_o(rx_n), .rise_count_o(rise_n)
   );
   // ==========================================================
   // Compare and bus tasks
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk_range(input int got, input int lo, input int hi);
      check_count++;
      if (got < lo || got > hi)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h to %h", $time, got, lo, hi);
      end
   endtask : chk_range
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_i);
      req <= {a, d, 2'b10};
      @(posedge clock_i);
      req <= '0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      req <= {a, 8'h00, 2'b01};
      @(posedge clock_i);
      req <= '0;
      #1;
      chk8(rdata, exp);
   endtask : rd
   task automatic wait_irq(input int lo, input int hi);
      int n;
      n = 0;
      #1;
      while (irq !== 1'b1 && n <= hi)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      chk_range(n, lo, hi);
   endtask : wait_irq
   task automatic pulse_low(input logic on_trig);
      @(posedge clock_i);
      if (on_trig) trig <= 1'b0;
      else pin_drv <= 1'b0;
      repeat (4) @(posedge clock_i);
      trig <= 1'b1;
      pin_drv <= 1'b1;
      repeat (4) @(posedge clock_i);
      #1;
   endtask : pulse_low
   task automatic measure(input int n);
      @(posedge clock_i);
      clear <= 1'b1;
      irq_n = 0;
      @(posedge clock_i);
      clear <= 1'b0;
      repeat (n)
      begin
         @(posedge clock_i);
         #1;
         irq_n += int'(irq === 1'b1);
      end
   endtask : measure
   // ==========================================================
   // Scenarios
   task automatic t_reset;
      chk8({6'h00, pin_out, oe_n, irq}, 8'h06);
      for (int a = 0; a < 16; a++) rd(a[3:0], 8'h00);
      wr(`ADDR_MODE, 8'hFF);
      rd(`ADDR_MODE, 8'h03);
      wr(`ADDR_IRQ_ENABLE, 8'hFF);
      rd(`ADDR_IRQ_ENABLE, 8'hBF);
      wr(4'h9, 8'hFF);
      rd(4'h9, 8'h00);
      wr(`ADDR_MODE, 8'h00);
      $display("Test reset done");
   endtask : t_reset
   task automatic t_timer;
      wr(`ADDR_IRQ_ENABLE, 8'hA0);
      wr(`ADDR_RELOAD_LOW, 8'h34);
      wr(`ADDR_RELOAD_HIGH, 8'h12);
      wr(`ADDR_COUNT_LOW, 8'hFC);
      wr(`ADDR_COUNT_HIGH, 8'hFF);
      wr(`ADDR_CONTROL, 8'h04);
      wait_irq(37, 50);
      rd(`ADDR_COUNT_HIGH, 8'h12);
      rd(`ADDR_CONTROL, 8'h84);
      wr(`ADDR_CONTROL, 8'h00);
      rd(`ADDR_CONTROL, 8'h00);
      $display("Test timer done");
   endtask : t_timer
   task automatic t_counter;
      wr(`ADDR_MODE, 8'h02);
      wr(`ADDR_CONTROL, 8'h02);
      wr(`ADDR_COUNT_LOW, 8'hFF);
      wr(`ADDR_COUNT_HIGH, 8'hFE);
      wr(`ADDR_CONTROL, 8'h06);
      pulse_low(1'b0);
      chk8({7'h00, oe_n}, 8'h01);
      wr(`ADDR_CONTROL, 8'h02);
      rd(`ADDR_COUNT_HIGH, 8'hFF);
      rd(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_COUNT_LOW, 8'hFF);
      wr(`ADDR_CONTROL, 8'h06);
      pulse_low(1'b0);
      chk8({7'h00, irq}, 8'h01);
      wr(`ADDR_CONTROL, 8'h00);
      $display("Test counter done");
   endtask : t_counter
   task automatic t_baud;
      wr(`ADDR_RELOAD_LOW, 8'hFE);
      wr(`ADDR_RELOAD_HIGH, 8'hFF);
      wr(`ADDR_COUNT_LOW, 8'hFE);
      wr(`ADDR_COUNT_HIGH, 8'hFF);
      wr(`ADDR_CONTROL, 8'h34);
      measure(400);
      chk_range(tx_n, 99, 101);
      chk_range(rx_n, 99, 101);
      chk_range(rise_n, 49, 51);
      chk_range(irq_n, 0, 0);
      rd(`ADDR_CONTROL, 8'h34);
      wr(`ADDR_CONTROL, 8'h14);
      measure(400);
      chk_range(tx_n, 99, 101);
      chk_range(rx_n, 39, 41);
      $display("Test baud done");
   endtask : t_baud
   task automatic t_edge;
      wr(`ADDR_CONTROL, 8'h3C);
      pulse_low(1'b1);
      wait_irq(0, 4);
      rd(`ADDR_CONTROL, 8'h7C);
      wr(`ADDR_CONTROL, 8'h3C);
      wr(`ADDR_IRQ_ENABLE, 8'h20);
      pulse_low(1'b1);
      chk8({7'h00, irq}, 8'h00);
      wr(`ADDR_IRQ_ENABLE, 8'h80);
      // Let the new enable reach the registered request first
      @(posedge clock_i);
      #1;
      chk8({7'h00, irq}, 8'h00);
      rd(`ADDR_CONTROL, 8'h7C);
      wr(`ADDR_IRQ_ENABLE, 8'hA0);
      wait_irq(1, 3);
      $display("Test edge done");
   endtask : t_edge
   // Clock enable low must hold the running timer still
   task automatic t_freeze;
      wr(`ADDR_MODE, 8'h00);
      wr(`ADDR_CONTROL, 8'h00);
      wr(`ADDR_COUNT_LOW, 8'h00);
      wr(`ADDR_COUNT_HIGH, 8'h00);
      wr(`ADDR_CONTROL, 8'h04);
      @(posedge clock_i);
      enable_i <= 1'b0;
      repeat (100) @(posedge clock_i);
      enable_i <= 1'b1;
      wr(`ADDR_CONTROL, 8'h00);
      rd(`ADDR_COUNT_LOW, 8'h00);
      $display("Test freeze done");
   endtask : t_freeze
   task automatic complete_run;
      $display("Checks %0d, mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      t_reset;
      t_timer;
      t_counter;
      t_baud;
      t_edge;
      t_freeze;
      complete_run;
   end
endmodule : tb_top
